// ### hdl/spg_interval_timer.sv
// interval timer: one-shot count of clock cycles, ends with a one-cycle pulse
`timescale 1ns/1ps
module spg_interval_timer #(
  parameter logic [spg_pkg::TIMER_W-1:0] INTERVAL = spg_pkg::INTERVAL_DFLT
) (
  input  wire logic clk_sys, // system clock
  input  wire logic rst,     // async reset, active high
  input  wire logic start,   // begin timing
  output logic      busy,    // timing in progress
  output logic      expired  // pulse when interval ends
);
  logic [spg_pkg::TIMER_W-1:0] count_r;
  logic                        busy_r;
  logic                        expired_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_r   <= '0;
      busy_r    <= 1'b0;
      expired_r <= 1'b0;
    end else begin
      expired_r <= 1'b0;
      if (start) begin
        count_r <= INTERVAL;
        busy_r  <= 1'b1;
      end else if (busy_r) begin
        if (count_r == spg_pkg::TMR_ONE) begin
          busy_r    <= 1'b0;
          expired_r <= 1'b1;
        end
        count_r <= count_r - spg_pkg::TMR_ONE;
      end
    end
  end

  assign busy    = busy_r;
  assign expired = expired_r;
endmodule : spg_interval_timer

// ### hdl/spg_pkg.sv
// constants and types shared by the stepper pulse generator
package spg_pkg;
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned IDX_W          = 6;
  localparam int unsigned SEL_W          = 3;
  localparam int unsigned TIMER_W        = 16;
  localparam int unsigned NUM_CMP        = 8;
  localparam logic [IDX_W-1:0] RAMP_STEP_COUNT = 6'h31;   // 49 transfers per ramp
  localparam logic [IDX_W-1:0] IDX_BOTTOM      = 6'h00;
  localparam logic [IDX_W-1:0] IDX_TOP         = 6'h30;   // 48, last of 49 entries
  localparam logic [IDX_W-1:0] IDX_STEP        = 6'h01;
  localparam logic [CNT_W-1:0] NO_OVERLAP_DFLT = 16'h0064; // 100 cycles
  localparam logic [TIMER_W-1:0] INTERVAL_DFLT = 16'hBDDD; // 48605 cycles
  localparam int unsigned TBL_BASE_PERIOD = 15000;
  localparam int unsigned TBL_PERIOD_STEP = 200;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
  localparam logic [TIMER_W-1:0] TMR_ONE = 16'h0001;

  // compare register slots
  localparam logic [SEL_W-1:0] SEL_A_SET     = 3'h0;
  localparam logic [SEL_W-1:0] SEL_A_CLR     = 3'h1;
  localparam logic [SEL_W-1:0] SEL_A_BAR_SET = 3'h2;
  localparam logic [SEL_W-1:0] SEL_A_BAR_CLR = 3'h3;
  localparam logic [SEL_W-1:0] SEL_B_SET     = 3'h4;
  localparam logic [SEL_W-1:0] SEL_B_CLR     = 3'h5;
  localparam logic [SEL_W-1:0] SEL_B_BAR_SET = 3'h6;
  localparam logic [SEL_W-1:0] SEL_B_BAR_CLR = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ACCEL = 3'h1,
    ST_CONST = 3'h3,
    ST_DECEL = 3'h2,
    ST_STOP  = 3'h6
  } spg_state_type;
endpackage : spg_pkg

// ### hdl/spg_stepper.sv
// two-phase stepping motor pulse generator with table-driven ramps
`timescale 1ns/1ps
module spg_stepper #(
  parameter logic [spg_pkg::CNT_W-1:0]   NO_OVERLAP_COUNT = spg_pkg::NO_OVERLAP_DFLT,
  parameter logic [spg_pkg::TIMER_W-1:0] INTERVAL_COUNT   = spg_pkg::INTERVAL_DFLT
) (
  input  wire logic clk_sys,            // 40 MHz system clock
  input  wire logic rst,                // async reset, active high
  input  wire logic start,              // one-cycle start command
  output logic      phase_a_out,        // A phase drive
  output logic      phase_a_bar_out,    // A-bar phase drive
  output logic      phase_b_out,        // B phase drive
  output logic      phase_b_bar_out,    // B-bar phase drive
  output logic      period_match_event, // pulse on period compare match
  output logic      transfer_done,      // pulse after each table transfer
  output logic      reverse_run,        // current run direction
  output logic      pulse_running,      // counters running
  output logic      ramp_active         // acceleration or deceleration
);
  // nominal table word for one slot at one ramp index; period shrinks with index
  function automatic logic [spg_pkg::CNT_W-1:0] tbl_word(input logic [spg_pkg::SEL_W-1:0] sel,
                                                         input logic [spg_pkg::IDX_W-1:0] idx);
    int unsigned p;
    int unsigned v;
    p = spg_pkg::TBL_BASE_PERIOD - spg_pkg::TBL_PERIOD_STEP * int'(idx);
    case (sel)
      spg_pkg::SEL_A_SET:     v = p;
      spg_pkg::SEL_A_CLR:     v = p / 2;
      spg_pkg::SEL_A_BAR_SET: v = p / 2;
      spg_pkg::SEL_A_BAR_CLR: v = p;
      spg_pkg::SEL_B_SET:     v = p / 4;
      spg_pkg::SEL_B_CLR:     v = (3 * p) / 4;
      spg_pkg::SEL_B_BAR_SET: v = (3 * p) / 4;
      spg_pkg::SEL_B_BAR_CLR: v = p / 4;
      default:                v = p;
    endcase
    return v[spg_pkg::CNT_W-1:0];
  endfunction : tbl_word

  // source slot for a destination; reverse swaps B-phase sources
  function automatic logic [spg_pkg::SEL_W-1:0] src_sel(input logic [spg_pkg::SEL_W-1:0] dst,
                                                        input logic rev);
    logic [spg_pkg::SEL_W-1:0] s;
    s = dst;
    if (rev) begin
      case (dst)
        spg_pkg::SEL_B_SET:     s = spg_pkg::SEL_B_BAR_CLR;
        spg_pkg::SEL_B_CLR:     s = spg_pkg::SEL_B_BAR_SET;
        spg_pkg::SEL_B_BAR_SET: s = spg_pkg::SEL_B_CLR;
        spg_pkg::SEL_B_BAR_CLR: s = spg_pkg::SEL_B_SET;
        default:                s = dst;
      endcase
    end
    return s;
  endfunction : src_sel

  // value loaded into a destination; clear slots are pulled early by the gap
  function automatic logic [spg_pkg::CNT_W-1:0] load_word(input logic [spg_pkg::SEL_W-1:0] dst,
                                                          input logic [spg_pkg::IDX_W-1:0] idx,
                                                          input logic rev);
    logic [spg_pkg::CNT_W-1:0] w;
    w = tbl_word(src_sel(dst, rev), idx);
    if (dst[0])
      w = w - NO_OVERLAP_COUNT;
    return w;
  endfunction : load_word

  spg_pkg::spg_state_type      state_r;
  logic                        rev_r;
  logic [spg_pkg::IDX_W-1:0]   idx_r;
  logic [spg_pkg::IDX_W-1:0]   xfer_cnt_r;
  logic [spg_pkg::CNT_W-1:0]   cnt_r;
  logic [spg_pkg::CNT_W-1:0]   cmp_r [spg_pkg::NUM_CMP];
  logic [3:0]                  out_r;
  logic                        xfer_evt_r;
  logic                        running;
  logic                        ramping;
  logic                        pmatch;
  logic                        do_xfer;
  logic                        last_xfer;
  logic                        tmr_start;
  logic                        tmr_busy;
  logic                        tmr_expired;
  logic                        go_accel;

  assign running   = (state_r == spg_pkg::ST_ACCEL) || (state_r == spg_pkg::ST_CONST) ||
                     (state_r == spg_pkg::ST_DECEL);
  assign ramping   = (state_r == spg_pkg::ST_ACCEL) || (state_r == spg_pkg::ST_DECEL);
  assign pmatch    = running && (cnt_r == cmp_r[spg_pkg::SEL_A_SET]);
  assign do_xfer   = pmatch && ramping && (xfer_cnt_r != spg_pkg::RAMP_STEP_COUNT);
  assign last_xfer = do_xfer && (xfer_cnt_r == spg_pkg::RAMP_STEP_COUNT - spg_pkg::IDX_STEP);
  assign go_accel  = (state_r == spg_pkg::ST_IDLE && start) ||
                     (state_r == spg_pkg::ST_STOP && tmr_expired);
  assign tmr_start = last_xfer;

  // one timer serves both constant run and stop, so both intervals are equal
  spg_interval_timer #(
    .INTERVAL (INTERVAL_COUNT)
  ) u_interval_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (tmr_start),
    .busy    (tmr_busy),
    .expired (tmr_expired)
  );

  // run sequence
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= spg_pkg::ST_IDLE;
    end else begin
      case (state_r)
        spg_pkg::ST_IDLE:  if (start) state_r <= spg_pkg::ST_ACCEL;
        spg_pkg::ST_ACCEL: if (last_xfer) state_r <= spg_pkg::ST_CONST;
        spg_pkg::ST_CONST: if (tmr_expired) state_r <= spg_pkg::ST_DECEL;
        spg_pkg::ST_DECEL: if (last_xfer) state_r <= spg_pkg::ST_STOP;
        spg_pkg::ST_STOP:  if (tmr_expired) state_r <= spg_pkg::ST_ACCEL;
        default:           state_r <= spg_pkg::ST_IDLE;
      endcase
    end
  end

  // direction flips after each stop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rev_r <= 1'b0;
    end else if (state_r == spg_pkg::ST_STOP && tmr_expired) begin
      rev_r <= ~rev_r;
    end
  end

  // shared table index and transfer count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idx_r      <= spg_pkg::IDX_BOTTOM;
      xfer_cnt_r <= '0;
    end else if (go_accel) begin
      idx_r      <= spg_pkg::IDX_BOTTOM;
      xfer_cnt_r <= '0;
    end else if (state_r == spg_pkg::ST_CONST && tmr_expired) begin
      idx_r      <= spg_pkg::IDX_TOP;
      xfer_cnt_r <= '0;
    end else if (do_xfer) begin
      xfer_cnt_r <= xfer_cnt_r + spg_pkg::IDX_STEP;
      if (last_xfer)
        idx_r <= idx_r;
      else if (state_r == spg_pkg::ST_ACCEL)
        idx_r <= idx_r + spg_pkg::IDX_STEP;
      else
        idx_r <= idx_r - spg_pkg::IDX_STEP;
    end
  end

  // compare registers: fixed destinations, one shared source index
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < spg_pkg::NUM_CMP; i++)
        cmp_r[i] <= spg_pkg::CNT_ZERO;
    end else if (go_accel) begin
      for (int i = 0; i < spg_pkg::NUM_CMP; i++)
        cmp_r[i] <= load_word(i[spg_pkg::SEL_W-1:0], spg_pkg::IDX_BOTTOM,
                              (state_r == spg_pkg::ST_STOP) ? ~rev_r : rev_r);
    end else if (do_xfer) begin
      for (int i = 0; i < spg_pkg::NUM_CMP; i++)
        cmp_r[i] <= load_word(i[spg_pkg::SEL_W-1:0], idx_r, rev_r);
    end
  end

  // common counter for both channels; halted outside a run
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= spg_pkg::CNT_ZERO;
    end else if (go_accel) begin
      cnt_r <= spg_pkg::CNT_ZERO;
    end else if (pmatch) begin
      cnt_r <= spg_pkg::CNT_ZERO;
    end else if (running) begin
      cnt_r <= cnt_r + spg_pkg::CNT_ONE;
    end
  end

  // phase outputs: set on first compare, clear on second, held when halted
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_r <= 4'h0;
    end else if (running) begin
      for (int ph = 0; ph < 4; ph++) begin
        if (cnt_r == cmp_r[2*ph])
          out_r[ph] <= 1'b1;
        else if (cnt_r == cmp_r[2*ph+1])
          out_r[ph] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xfer_evt_r <= 1'b0;
    end else begin
      xfer_evt_r <= do_xfer;
    end
  end

  assign phase_a_out        = out_r[0];
  assign phase_a_bar_out    = out_r[1];
  assign phase_b_out        = out_r[2];
  assign phase_b_bar_out    = out_r[3];
  assign period_match_event = pmatch;
  assign transfer_done      = xfer_evt_r;
  assign reverse_run        = rev_r;
  assign pulse_running      = running;
  assign ramp_active        = ramping;

  a_idle_outs_low: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == spg_pkg::ST_IDLE) |-> (out_r == 4'h0))
    else $error("outputs not low while idle");

  a_period_clears: assert property (@(posedge clk_sys) disable iff (rst)
    (pmatch && !go_accel) |=> (cnt_r == spg_pkg::CNT_ZERO))
    else $error("counter did not clear on period match");

  a_set_output: assert property (@(posedge clk_sys) disable iff (rst)
    (running && cnt_r == cmp_r[spg_pkg::SEL_B_SET]) |=> phase_b_out)
    else $error("phase B not set on its compare");

  a_clear_output: assert property (@(posedge clk_sys) disable iff (rst)
    (running && cnt_r == cmp_r[spg_pkg::SEL_A_CLR] && cnt_r != cmp_r[spg_pkg::SEL_A_SET]) |=> !phase_a_out)
    else $error("phase A not cleared on its compare");

  a_stop_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == spg_pkg::ST_STOP) ##1 (state_r == spg_pkg::ST_STOP) |-> $stable(out_r) && $stable(cnt_r))
    else $error("outputs or counter moved during stop");

  a_xfer_event: assert property (@(posedge clk_sys) disable iff (rst)
    do_xfer |=> transfer_done ##1 !transfer_done)
    else $error("transfer event missing or too long");

  a_accel_step: assert property (@(posedge clk_sys) disable iff (rst)
    (do_xfer && !last_xfer && state_r == spg_pkg::ST_ACCEL) |=> (idx_r == $past(idx_r) + spg_pkg::IDX_STEP))
    else $error("acceleration index did not advance");

  a_decel_step: assert property (@(posedge clk_sys) disable iff (rst)
    (do_xfer && !last_xfer && state_r == spg_pkg::ST_DECEL) |=> (idx_r == $past(idx_r) - spg_pkg::IDX_STEP))
    else $error("deceleration index did not retreat");

  a_ramp_length: assert property (@(posedge clk_sys) disable iff (rst)
    last_xfer |-> (idx_r == ((state_r == spg_pkg::ST_ACCEL) ? spg_pkg::IDX_TOP : spg_pkg::IDX_BOTTOM)))
    else $error("ramp ended at the wrong count");

  a_no_shoot: assert property (@(posedge clk_sys) disable iff (rst)
    !(phase_a_out && phase_a_bar_out) && !(phase_b_out && phase_b_bar_out))
    else $error("complementary phases driven together");

  a_timer_on_end: assert property (@(posedge clk_sys) disable iff (rst)
    (last_xfer && state_r == spg_pkg::ST_ACCEL) |=> (tmr_busy && state_r == spg_pkg::ST_CONST))
    else $error("constant interval not started after ramp");

  a_stop_rearm: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == spg_pkg::ST_STOP && tmr_expired) |=> (state_r == spg_pkg::ST_ACCEL && idx_r == spg_pkg::IDX_BOTTOM))
    else $error("acceleration not re-armed after stop");
endmodule : spg_stepper

// ### verif/spg_driver_model.sv
// behavioural driver power stage watching the four phase drives
`timescale 1ns/1ps
module spg_driver_model #(
  parameter int GAP = 100
) (
  input  wire logic clk_sys,         // system clock
  input  wire logic rst,             // async reset, active high
  input  wire logic phase_a_in,      // A phase drive
  input  wire logic phase_a_bar_in,  // A-bar phase drive
  input  wire logic phase_b_in,      // B phase drive
  input  wire logic phase_b_bar_in,  // B-bar phase drive
  output int        fault_count,     // overlaps, bad order, bad gaps
  output int        step_count,      // excited pair changes seen
  output int        gap_count        // gaps measured
);
  logic [3:0] ph_now;
  logic [3:0] ph_prev;
  int         fall_at [4];
  int         now;
  int         last_pair;
  int         pair;

  assign ph_now = {phase_a_in, phase_a_bar_in, phase_b_in, phase_b_bar_in};

  // bit 3 a, 2 a-bar, 1 b, 0 b-bar; complement of bit i is i^1
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_count = 0;
      step_count  = 0;
      gap_count   = 0;
      ph_prev   = 4'h0;
      fall_at   = '{-1, -1, -1, -1};
      last_pair = -1;
      now       = 0;
    end else begin
      now++;
      case (ph_now)
        4'b1001: pair = 0;
        4'b1010: pair = 1;
        4'b0110: pair = 2;
        4'b0101: pair = 3;
        default: pair = -1;
      endcase
      if ((ph_now[3] && ph_now[2]) || (ph_now[1] && ph_now[0])) fault_count++;
      if (pair >= 0 && pair != last_pair) begin
        if (last_pair >= 0 && pair != (last_pair + 1) % 4) fault_count++;
        step_count++;
        last_pair = pair;
      end
      for (int i = 0; i < 4; i++) begin
        if (ph_now[i] && !ph_prev[i] && fall_at[i ^ 1] >= 0) begin
          if (now - fall_at[i ^ 1] != GAP) fault_count++;
          gap_count++;
        end
        if (!ph_now[i] && ph_prev[i]) fall_at[i] = now;
      end
      ph_prev = ph_now;
    end
  end
endmodule : spg_driver_model

// ### verif/spg_stepper_tb.sv
// self-checking bench for the stepper pulse generator
`timescale 1ns/1ps
module spg_stepper_tb;
  localparam int GAP   = 10;
  localparam int LIMIT = 95000;
  logic clk_sys = 1'b0;
  logic rst     = 1'b1;
  logic start   = 1'b0;
  logic phase_a_out, phase_a_bar_out, phase_b_out, phase_b_bar_out;
  logic period_match_event, transfer_done, reverse_run, pulse_running, ramp_active;
  int   n_fail    = 0;
  int   cmp_count = 0;
  int   cyc       = 0;
  int   t_start;
  int   drv_faults, drv_steps, drv_gaps;

  spg_stepper #(.NO_OVERLAP_COUNT(16'(GAP)), .INTERVAL_COUNT(16'h0032)) uut (
    .clk_sys(clk_sys), .rst(rst), .start(start), .phase_a_out(phase_a_out),
    .phase_a_bar_out(phase_a_bar_out), .phase_b_out(phase_b_out), .phase_b_bar_out(phase_b_bar_out),
    .period_match_event(period_match_event), .transfer_done(transfer_done), .reverse_run(reverse_run),
    .pulse_running(pulse_running), .ramp_active(ramp_active));

  spg_driver_model #(.GAP(GAP)) drv (
    .clk_sys(clk_sys), .rst(rst), .phase_a_in(phase_a_out), .phase_a_bar_in(phase_a_bar_out),
    .phase_b_in(phase_b_out), .phase_b_bar_in(phase_b_bar_out), .fault_count(drv_faults),
    .step_count(drv_steps), .gap_count(drv_gaps));

  always #12.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] outs();
    return {23'h0, phase_a_out, phase_a_bar_out, phase_b_out, phase_b_bar_out,
            period_match_event, transfer_done, reverse_run, pulse_running, ramp_active};
  endfunction : outs

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      conclude();
    end
  end

  task automatic test_idle();
    repeat (20) @(negedge clk_sys);
    check("outputs idle", 32'h0, outs());
    $display("test idle done");
  endtask : test_idle

  task automatic test_start();
    @(posedge clk_sys) start <= 1'b1;
    @(posedge clk_sys) start <= 1'b0;
    @(negedge clk_sys);
    t_start = cyc;
    check("pulse_running", 32'h1, {31'h0, pulse_running});
    check("ramp_active", 32'h1, {31'h0, ramp_active});
    check("reverse_run", 32'h0, {31'h0, reverse_run});
    $display("test start done");
  endtask : test_start

  task automatic wait_match(output int at);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (period_match_event !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    at = cyc;
    check("period_match_event", 32'h1, {31'h0, period_match_event});
  endtask : wait_match

  task automatic test_periods();
    int   t [5];
    logic td;
    for (int k = 0; k < 5; k++) begin
      wait_match(t[k]);
      td = 1'b0;
      repeat (2) begin
        @(negedge clk_sys);
        if (transfer_done === 1'b1) td = 1'b1;
      end
      check("transfer_done", 32'h1, {31'h0, td});
      if (k == 1) begin
        // a start while running must not restart the ramp
        @(posedge clk_sys) start <= 1'b1;
        @(posedge clk_sys) start <= 1'b0;
      end
    end
    check("first period", spg_pkg::TBL_BASE_PERIOD, t[0] - t_start);
    check("bottom entry period", spg_pkg::TBL_BASE_PERIOD + 1, t[1] - t[0]);
    check("period step", t[3] - t[2] - spg_pkg::TBL_PERIOD_STEP, t[4] - t[3]);
    check("period step", t[2] - t[1] - spg_pkg::TBL_PERIOD_STEP, t[3] - t[2]);
    check("still ramping", 32'h1, {31'h0, ramp_active & pulse_running});
    $display("test periods done");
  endtask : test_periods

  task automatic test_driver();
    check("driver faults", 32'h0, drv_faults);
    check("pair steps", 32'h1, {31'h0, drv_steps >= 16});
    check("gaps measured", 32'h1, {31'h0, drv_gaps >= 16});
    $display("test driver done");
  endtask : test_driver

  task automatic test_reset_mid();
    @(posedge clk_sys) rst <= 1'b1;
    @(negedge clk_sys);
    check("outputs in reset", 32'h0, outs());
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (10) @(negedge clk_sys);
    check("outputs after reset", 32'h0, outs());
    $display("test reset mid-run done");
  endtask : test_reset_mid

  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    test_idle();
    test_start();
    test_periods();
    test_driver();
    test_reset_mid();
    conclude();
  end
endmodule : spg_stepper_tb
